// ==== hw/dac_frame_pkg.sv ====
// shared constants for the serial converter write frame
package dac_frame_pkg;
	localparam int          FRAME_BITS     = 24;
	localparam int          CNT_W          = 5;
	localparam logic [4:0]  FRAME_LAST     = 5'h17;
	localparam int          MODE_HI_POS    = 17;
	localparam int          MODE_LO_POS    = 16;
	localparam int          CODE_W         = 16;
	localparam int          BYTE_BITS      = 8;
	localparam logic [15:0] CODE_MIDSCALE  = 16'h0000;
	localparam real         SYNC_HIGH_NS   = 33.0;
	localparam real         CLK_PERIOD_NS  = 10.0;
	localparam int          SYNC_HIGH_CYC  = int'($ceil(SYNC_HIGH_NS / CLK_PERIOD_NS));
	localparam int          SCLK_HALF_CYC  = 4;

	typedef enum logic [1:0] {
		MODE_NORMAL   = 2'b00,
		MODE_PD_1K    = 2'b01,
		MODE_PD_100K  = 2'b10,
		MODE_PD_HIGHZ = 2'b11
	} power_mode_type;
endpackage : dac_frame_pkg

// ==== hw/dac_frame_rx.sv ====
// converter end: shifts the 24-bit frame on the link clock, hands results to clk
`timescale 1ns/10ps
// Overview of operation
// - 24-bit frame, top six bits ignored
// - bits 17 and 16 select power mode
// - low 16 bits load on 24th edge
// - update on exactly the 24th falling edge
// - early frame select rise discards frame
// - bits shifted in msb first
// - byte hosts hold select over three bytes
// - host uses clock polarity 0, phase 1
// - code is two's complement, zero is midscale
// - mode 00 normal, others power-down variants
// - select high 33 ns before new frame
// - midscale held until first valid frame
// - power-down frame still loads its code
module dac_frame_rx (
	// system
	input  wire logic                        clk,
	input  wire logic                        srst,
	// link
	dac_link_if.device                       link,
	// converter side
	output logic signed [15:0]               code_r,
	output dac_frame_pkg::power_mode_type    mode_r,
	output logic                             pd_1k_r,
	output logic                             pd_100k_r,
	output logic                             pd_highz_r,
	output logic                             update_r
);
	// link domain: falling edge of sclk; sync_n high clears asynchronously,
	// since no sclk edges run while select is high
	logic [22:0] shift_r;
	logic [4:0]  cnt_r;
	logic        done_r;
	logic [17:0] frame_r;
	logic        tog_r;
	logic        sync_hi;

	assign sync_hi = link.sync_n;

	always_ff @(negedge link.sclk or posedge sync_hi) begin
		if (sync_hi) begin
			shift_r <= 23'h000000;
			cnt_r   <= 5'h00;
			done_r  <= 1'b0;
		end else if (!done_r) begin
			shift_r <= {shift_r[21:0], link.sdata};
			cnt_r   <= cnt_r + 5'h01;
			if (cnt_r == dac_frame_pkg::FRAME_LAST) begin
				done_r <= 1'b1;
			end
		end
	end

	// capture frame payload and signal clk domain by toggle; upper bits dropped
	always_ff @(negedge link.sclk or posedge srst) begin
		if (srst) begin
			frame_r <= 18'h00000;
			tog_r   <= 1'b0;
		end else if (!sync_hi && !done_r && cnt_r == dac_frame_pkg::FRAME_LAST) begin
			frame_r <= {shift_r[16:0], link.sdata};
			tog_r   <= ~tog_r;
		end
	end

	// clk domain: synchronise toggle, frame_r is stable when toggle lands
	logic tog_s1_r;
	logic tog_s2_r;
	logic tog_s3_r;

	always_ff @(posedge clk) begin
		if (srst) begin
			tog_s1_r <= 1'b0;
			tog_s2_r <= 1'b0;
			tog_s3_r <= 1'b0;
		end else begin
			tog_s1_r <= tog_r;
			tog_s2_r <= tog_s1_r;
			tog_s3_r <= tog_s2_r;
		end
	end

	logic                           new_frame;
	dac_frame_pkg::power_mode_type  mode_nxt;

	assign new_frame = tog_s2_r ^ tog_s3_r;
	assign mode_nxt  = dac_frame_pkg::power_mode_type'({
		frame_r[dac_frame_pkg::MODE_HI_POS], frame_r[dac_frame_pkg::MODE_LO_POS]});

	always_ff @(posedge clk) begin
		if (srst) begin
			code_r   <= dac_frame_pkg::CODE_MIDSCALE;
			mode_r   <= dac_frame_pkg::MODE_NORMAL;
			update_r <= 1'b0;
		end else begin
			update_r <= new_frame;
			if (new_frame) begin
				// code kept regardless of mode
				code_r <= frame_r[dac_frame_pkg::CODE_W-1:0];
				mode_r <= mode_nxt;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pd_1k_r    <= 1'b0;
			pd_100k_r  <= 1'b0;
			pd_highz_r <= 1'b0;
		end else if (new_frame) begin
			pd_1k_r    <= (mode_nxt == dac_frame_pkg::MODE_PD_1K);
			pd_100k_r  <= (mode_nxt == dac_frame_pkg::MODE_PD_100K);
			pd_highz_r <= (mode_nxt == dac_frame_pkg::MODE_PD_HIGHZ);
		end
	end
endmodule : dac_frame_rx

// ==== hw/dac_frame_tx.sv ====
// host end: sends a 24-bit frame, sclk divided from clk
`timescale 1ns/10ps
module dac_frame_tx (
	// system
	input  wire logic                     clk,
	input  wire logic                     srst,
	// link
	dac_link_if.host                      link,
	// user request
	input  wire logic                     start,
	input  wire logic [15:0]              code,
	input  wire dac_frame_pkg::power_mode_type mode,
	input  wire logic                     abort,
	output logic                          busy_r,
	output logic                          done_r
);
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SHIFT = 2'b01,
		ST_GAP   = 2'b10
	} tx_state_type;

	tx_state_type state_r;
	logic [23:0]  data_r;
	logic [4:0]   bit_r;
	logic [2:0]   div_r;
	logic [2:0]   gap_r;
	logic         sclk_r;
	logic         sync_n_r;

	assign link.sclk   = sclk_r;
	assign link.sync_n = sync_n_r;
	assign link.sdata  = data_r[dac_frame_pkg::FRAME_BITS-1];

	// one 24-bit frame; byte boundaries never raise select
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r  <= ST_IDLE;
			data_r   <= 24'h000000;
			bit_r    <= 5'h00;
			div_r    <= 3'h0;
			gap_r    <= 3'h0;
			sclk_r   <= 1'b0;
			sync_n_r <= 1'b1;
			busy_r   <= 1'b0;
			done_r   <= 1'b0;
		end else begin
			done_r <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					sclk_r <= 1'b0; // polarity 0
					if (start) begin
						data_r   <= {6'h00, mode, code};
						bit_r    <= 5'h00;
						div_r    <= 3'h0;
						sync_n_r <= 1'b0;
						busy_r   <= 1'b1;
						state_r  <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (abort) begin
						sync_n_r <= 1'b1;
						sclk_r   <= 1'b0;
						gap_r    <= 3'h0;
						state_r  <= ST_GAP;
					end else if (div_r == 3'(dac_frame_pkg::SCLK_HALF_CYC - 1)) begin
						div_r  <= 3'h0;
						sclk_r <= ~sclk_r;
						if (sclk_r) begin
							// falling edge: device samples; shift after it
							if (bit_r == dac_frame_pkg::FRAME_LAST) begin
								// select rises a clk later, never on the last fall itself
								gap_r    <= 3'h0;
								done_r   <= 1'b1;
								state_r  <= ST_GAP;
							end else begin
								bit_r  <= bit_r + 5'h01;
							end
						end else if (bit_r != 5'h00) begin
							data_r <= {data_r[22:0], 1'b0};
						end
					end else begin
						div_r <= div_r + 3'h1;
					end
				end
				ST_GAP: begin
					sync_n_r <= 1'b1;
					if (gap_r == 3'(dac_frame_pkg::SYNC_HIGH_CYC)) begin
						busy_r  <= 1'b0;
						state_r <= ST_IDLE;
					end else begin
						gap_r <= gap_r + 3'h1;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end
endmodule : dac_frame_tx

// ==== hw/dac_link_if.sv ====
// three-wire write link between host and converter
`timescale 1ns/10ps
interface dac_link_if;
	logic sclk;
	logic sync_n;
	logic sdata;

	modport host (
		output sclk,
		output sync_n,
		output sdata
	);
	modport device (
		input  sclk,
		input  sync_n,
		input  sdata
	);
endinterface : dac_link_if

// ==== sim/serial_dac_input_frame_props.sv ====
// link and completion checks for the converter write frame
`timescale 1ns/10ps
module serial_dac_input_frame_props (
	// system
	input wire logic clk,
	input wire logic srst,
	// link
	input wire logic sclk,
	input wire logic sync_n,
	input wire logic sdata,
	// completion
	input wire logic done_r,
	input wire logic update_r
);
	logic       sclk_q;
	logic [4:0] falls_r;
	logic [3:0] since_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	always_ff @(posedge clk) begin
		sclk_q <= sclk;
	end
	// falls seen on clk, so the link clock must stay well below clk/2
	always_ff @(posedge clk) begin
		if (srst || sync_n) begin
			falls_r <= 5'h00;
		end else if (sclk_q && !sclk) begin
			falls_r <= falls_r + 5'h01;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			since_r <= 4'hf;
		end else if (done_r) begin
			since_r <= 4'h0;
		end else if (since_r != 4'hf) begin
			since_r <= since_r + 4'h1;
		end
	end
	sequence last_fall_s;
		$fell(sclk) && !sync_n && falls_r == 5'h17;
	endsequence
	idle_clock_low_a: assert property (sync_n && $past(sync_n) |-> !sclk)
		else $error("link clock high outside a frame");
	data_stable_a: assert property ($fell(sclk) |-> $stable(sdata))
		else $error("data moved at a falling link edge");
	select_gap_a: assert property ($rose(sync_n) |-> sync_n[*4])
		else $error("frame select high too short");
	half_period_a: assert property ($rose(sclk) |-> (sclk || sync_n)[*4])
		else $error("link clock high phase too short");
	fall_cap_a: assert property (falls_r <= 5'h18)
		else $error("more than 24 falls in one frame");
	done_on_last_a: assert property (last_fall_s |-> ##[0:2] done_r)
		else $error("no completion at the last fall");
	update_follows_a: assert property (done_r |-> ##[1:6] update_r)
		else $error("no update after a complete frame");
	update_cause_a: assert property (update_r |-> since_r < 4'h6)
		else $error("update without a complete frame");
	update_pulse_a: assert property (update_r |=> !update_r)
		else $error("update longer than one cycle");
endmodule : serial_dac_input_frame_props

// ==== sim/serial_dac_input_frame_tb.sv ====
// randomised bench with both link ends in the loop
`timescale 1ns/10ps
module serial_dac_input_frame_tb;
	logic                          clk;
	logic                          srst;
	logic                          start;
	logic                          abort;
	logic [15:0]                   code;
	dac_frame_pkg::power_mode_type mode;
	logic                          busy_r;
	logic                          done_r;
	logic                          update_r;
	logic signed [15:0]            code_r;
	dac_frame_pkg::power_mode_type mode_r;
	wire [2:0]                     pd_r;
	logic [23:0]                   wire_sh;
	int                            failures;
	int                            compares;
	int                            cycles;
	dac_link_if link ();
	dac_frame_tx i_dac_frame_tx (.clk(clk), .srst(srst), .link(link), .start(start),
		.code(code), .mode(mode), .abort(abort), .busy_r(busy_r), .done_r(done_r));
	dac_frame_rx i_dac_frame_rx (.clk(clk), .srst(srst), .link(link), .code_r(code_r),
		.mode_r(mode_r), .pd_1k_r(pd_r[0]), .pd_100k_r(pd_r[1]), .pd_highz_r(pd_r[2]),
		.update_r(update_r));
	serial_dac_input_frame_props i_props (.clk(clk), .srst(srst), .sclk(link.sclk),
		.sync_n(link.sync_n), .sdata(link.sdata), .done_r(done_r), .update_r(update_r));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// about 200 cycles a frame; the ceiling leaves wide margin
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			failures++;
			finish_test();
		end
	end
	always @(negedge link.sclk) begin
		if (!link.sync_n) begin
			wire_sh <= {wire_sh[22:0], link.sdata};
		end
	end
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	function automatic logic [2:0] exp_pd(input logic [1:0] m);
		return {m == 2'b11, m == 2'b10, m == 2'b01};
	endfunction : exp_pd
	task automatic finish_test();
		if (failures == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test
	task automatic send(input logic [15:0] c, input logic [1:0] m, input bit ab);
		logic [17:0] old;
		old = {mode_r, code_r};
		code = c;
		mode = dac_frame_pkg::power_mode_type'(m);
		start = 1'b1;
		@(negedge clk) start = 1'b0;
		code = ~c;
		// a second start while busy must not replace the frame
		@(negedge clk) start = 1'b1;
		@(negedge clk) start = 1'b0;
		if (ab) begin
			repeat (60) @(negedge clk);
			abort = 1'b1;
			@(negedge clk iff !busy_r);
			abort = 1'b0;
			repeat (8) @(negedge clk);
			check(24'({mode_r, code_r}), 24'(old));
		end else begin
			@(posedge clk iff update_r);
			repeat (2) @(negedge clk);
			check(24'(wire_sh[17:0]), 24'({m, c}));
			check(24'({mode_r, code_r}), 24'({m, c}));
			check(24'(pd_r), 24'(exp_pd(m)));
		end
		@(negedge clk iff !busy_r);
	endtask : send
	initial begin
		logic [15:0] corner [4];
		corner = '{16'h8000, 16'h7fff, 16'h0000, 16'hffff};
		void'($urandom(32'h98c5));
		srst = 1'b1;
		start = 1'b0;
		abort = 1'b0;
		code = 16'h0000;
		mode = dac_frame_pkg::MODE_NORMAL;
		repeat (20) @(negedge clk);
		srst = 1'b0;
		check(24'({mode_r, code_r}), 24'(dac_frame_pkg::CODE_MIDSCALE));
		for (int i = 0; i < 4; i++) send(corner[i], 2'(i), 1'b0);
		for (int i = 0; i < 9; i++) send(16'($urandom()), 2'($urandom()), i % 3 == 1);
		finish_test();
	end
endmodule : serial_dac_input_frame_tb
